// ---- pkg/dls_pkg.sv ----
// package: constants and types of the data link status block
`default_nettype none
// Summary of operation
// - running flag set in run or monitor
// - running flag kept through fatal error
// - error flag follows node fatal error
// - run and error invalid under comm error
// - comm error set while node sends nothing
// - participation flag sticky once set
// - participation clear until first participation
// - bit 15 of word 23 shows local activity
// - node flags valid only while locally active
// - startup address 1 to 62 in bits 13:8
// - four nodes per word in words 8 to 22, two nodes in word 23
// - node flags frozen while locally inactive
package dls_pkg;
  localparam int unsigned NODE_COUNT = 62;
  localparam int unsigned SLOT_W = 6;
  localparam int unsigned WORD_COUNT = 16;
  localparam int unsigned ADDR_W = 8;
  localparam logic [5:0] IDX_FIRST_WORD = 6'h08;
  localparam logic [5:0] IDX_LOCAL_WORD = 6'h17;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h18;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h19;
  localparam logic [5:0] IDX_SUMMARY = 6'h1a;
  localparam int unsigned FLG_RUN = 0;
  localparam int unsigned FLG_ERR = 1;
  localparam int unsigned FLG_CERR = 2;
  localparam int unsigned FLG_PART = 3;
  localparam int unsigned LOCAL_ACTIVE_BIT = 15;
  localparam int unsigned SUM_ERR_BIT = 8;
  localparam logic [5:0] STARTUP_MIN = 6'h01;
  localparam logic [5:0] STARTUP_MAX = 6'h3e;
  localparam logic [5:0] STARTUP_RESET = 6'h00;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam int unsigned EV_W = 4;
  localparam int unsigned EV_LINK_UP = 0;
  localparam int unsigned EV_LINK_DOWN = 1;
  localparam int unsigned EV_COMM_ERR = 2;
  localparam int unsigned EV_STARTUP = 3;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {DLS_WR_IDLE = 2'b01, DLS_WR_RESP = 2'b10} dls_wr_e;
  typedef enum logic [1:0] {DLS_RD_IDLE = 2'b01, DLS_RD_RESP = 2'b10} dls_rd_e;
endpackage : dls_pkg
`default_nettype wire

// ---- pkg/dls_node_if.sv ----
// interface: frame broadcast from the top to the node slots
`default_nettype none
interface dls_node_if;
  import dls_pkg::*;
  logic frame_valid;
  logic [SLOT_W-1:0] frame_slot;
  logic frame_run;
  logic frame_fatal;
  logic commit;
  modport src (output frame_valid, frame_slot, frame_run, frame_fatal, commit);
  modport slot (input frame_valid, frame_slot, frame_run, frame_fatal, commit);
endinterface : dls_node_if
`default_nettype wire

// ---- design/dls_node_slot.sv ----
// module: four status flags of one node in the link table
`default_nettype none
module dls_node_slot
  import dls_pkg::*;
#(
  parameter logic [SLOT_W-1:0] SLOT = 6'h00
) (
  input wire logic aclk,
  input wire logic aresetn,
  dls_node_if.slot bus,
  output logic [3:0] flags,
  output logic comm_err_set
);
  typedef struct packed {
    logic [3:0] flags;
    logic seen;
    logic lat_run;
    logic lat_fatal;
    logic comm_err_set;
  } dls_slot_s;

  dls_slot_s s;
  dls_slot_s next_s;

  always_comb begin
    next_s = s;
    next_s.comm_err_set = 1'b0;
    if (bus.commit) begin
      if (s.seen) begin
        next_s.flags[FLG_CERR] = 1'b0;
        next_s.flags[FLG_PART] = 1'b1;
        next_s.flags[FLG_ERR] = s.lat_fatal;
        next_s.flags[FLG_RUN] = s.lat_fatal ? (s.flags[FLG_RUN] | s.lat_run) : s.lat_run;
      end else begin
        // run and error bits keep stale values, meaningless while silent
        next_s.flags[FLG_CERR] = 1'b1;
        next_s.comm_err_set = !s.flags[FLG_CERR];
      end
      next_s.seen = 1'b0;
    end
    if (bus.frame_valid && (bus.frame_slot == SLOT)) begin
      next_s.seen = 1'b1;
      next_s.lat_run = bus.frame_run;
      next_s.lat_fatal = bus.frame_fatal;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '{flags: FLAGS_RESET, default: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign flags = s.flags;
  assign comm_err_set = s.comm_err_set;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_fresh;
    bus.commit && s.seen;
  endsequence
  a_run_follow: assert property (
    s_fresh ##0 !s.lat_fatal |=> flags[FLG_RUN] == $past(s.lat_run))
    else $error("running flag not refreshed");
  a_run_kept: assert property (
    s_fresh ##0 s.lat_fatal && flags[FLG_RUN] |=> flags[FLG_RUN])
    else $error("running flag dropped on fatal error");
  a_err_follow: assert property (
    s_fresh |=> flags[FLG_ERR] == $past(s.lat_fatal))
    else $error("error flag not refreshed");
  a_cerr_silent: assert property (
    bus.commit && !s.seen |=> flags[FLG_CERR] && !flags[FLG_PART] == !$past(flags[FLG_PART]))
    else $error("silent node not flagged");
  a_part_sticky: assert property (
    flags[FLG_PART] |=> flags[FLG_PART])
    else $error("participation flag cleared");
  a_part_first: assert property (
    $rose(flags[FLG_PART]) |-> $past(bus.commit && s.seen))
    else $error("participation set without a frame");
endmodule : dls_node_slot
`default_nettype wire

// ---- design/dls_irq_bank.sv ----
// module: sticky event status, mask and interrupt line
`default_nettype none
module dls_irq_bank
  import dls_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [EV_W-1:0] events,
  input wire logic status_rd,
  input wire logic mask_wr,
  input wire logic [EV_W-1:0] mask_wdata,
  output logic [EV_W-1:0] status,
  output logic [EV_W-1:0] mask,
  output logic irq
);
  typedef struct packed {
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic irq;
  } dls_irq_s;

  dls_irq_s s;
  dls_irq_s next_s;

  always_comb begin
    next_s = s;
    // an event in the clearing cycle survives the read
    next_s.status = (status_rd ? STATUS_RESET : s.status) | events;
    if (mask_wr) begin
      next_s.mask = mask_wdata;
    end
    next_s.irq = |(next_s.status & next_s.mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '{status: STATUS_RESET, mask: MASK_RESET, irq: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign status = s.status;
  assign mask = s.mask;
  assign irq = s.irq;

  a_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    status_rd && (events != STATUS_RESET) |=> (status & $past(events)) == $past(events))
    else $error("event lost under read clear");
endmodule : dls_irq_bank
`default_nettype wire

// ---- design/dls_link_status.sv ----
// module: data link status flags behind an axi4-lite register slave
//
// Added by the designer: the AXI4-Lite interface to the registers.
`default_nettype none
module dls_link_status
  import dls_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic link_active,
  input wire logic frame_valid,
  input wire logic [SLOT_W-1:0] frame_slot,
  input wire logic frame_run,
  input wire logic frame_fatal,
  input wire logic cycle_end,
  input wire logic startup_valid,
  input wire logic [SLOT_W-1:0] startup_addr,
  output logic irq
);

  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    dls_wr_e wr;
    logic aw_got;
    logic w_got;
    logic [5:0] widx;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    dls_rd_e rd;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic active;
    logic [SLOT_W-1:0] startup;
    logic [SLOT_W-1:0] live;
    logic link_err;
  } dls_top_s;

  localparam dls_top_s TOP_RESET = '{
    wr: DLS_WR_IDLE,
    rd: DLS_RD_IDLE,
    startup: STARTUP_RESET,
    default: '0
  };

  dls_top_s s;
  dls_top_s next_s;

  logic [3:0] flag_q [NODE_COUNT];
  logic [NODE_COUNT-1:0] cerr_set;
  logic [15:0] word [WORD_COUNT];
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] irq_status;
  logic [EV_W-1:0] irq_mask;
  logic [EV_W-1:0] mask_wdata;
  logic status_rd;
  logic mask_wr;
  logic [5:0] aridx;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [SLOT_W-1:0] live_cnt;
  logic any_cerr;

  // ****************************************************
  // node slots
  // ****************************************************
  dls_node_if nbus ();

  // no frame and no refresh reach the slots while the local node is out
  assign nbus.frame_valid = frame_valid && s.active;
  assign nbus.frame_slot = frame_slot;
  assign nbus.frame_run = frame_run;
  assign nbus.frame_fatal = frame_fatal;
  assign nbus.commit = cycle_end && s.active;

  genvar g;
  for (g = 0; g < NODE_COUNT; g++) begin : g_slot
    dls_node_slot #(
      .SLOT(SLOT_W'(g))
    ) u_slot (
      .aclk(aclk),
      .aresetn(aresetn),
      .bus(nbus),
      .flags(flag_q[g]),
      .comm_err_set(cerr_set[g])
    );
  end

  // ****************************************************
  // status words
  // ****************************************************
  for (g = 0; g < WORD_COUNT - 1; g++) begin : g_word
    assign word[g] = {flag_q[4*g+3], flag_q[4*g+2], flag_q[4*g+1], flag_q[4*g]};
  end
  assign word[WORD_COUNT-1] = {
    s.active,
    1'b0,
    s.startup,
    flag_q[NODE_COUNT-1],
    flag_q[NODE_COUNT-2]
  };

  // live node count and any communications error
  always_comb begin
    live_cnt = '0;
    any_cerr = 1'b0;
    for (int i = 0; i < NODE_COUNT; i++) begin
      live_cnt = live_cnt + SLOT_W'(flag_q[i][FLG_PART] && !flag_q[i][FLG_CERR]);
      any_cerr = any_cerr | flag_q[i][FLG_CERR];
    end
  end

  // ****************************************************
  // interrupt events
  // ****************************************************
  dls_irq_bank u_irq (
    .aclk(aclk),
    .aresetn(aresetn),
    .events(ev),
    .status_rd(status_rd),
    .mask_wr(mask_wr),
    .mask_wdata(mask_wdata),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  assign mask_wdata = next_s.wdata[EV_W-1:0];

  // ****************************************************
  // read decode
  // ****************************************************
  assign aridx = s_axi_araddr[ADDR_W-1:2];

  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    if (aridx >= IDX_FIRST_WORD && aridx <= IDX_LOCAL_WORD) begin
      rd_word = 32'(word[4'(aridx - IDX_FIRST_WORD)]);
    end else if (aridx == IDX_IRQ_STATUS) begin
      rd_word = 32'(irq_status);
    end else if (aridx == IDX_IRQ_MASK) begin
      rd_word = 32'(irq_mask);
    end else if (aridx == IDX_SUMMARY) begin
      rd_word = 32'({s.link_err, 2'b00, s.live});
    end else begin
      rd_hit = 1'b0;
    end
  end

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    next_s = s;
    status_rd = 1'b0;
    mask_wr = 1'b0;
    ev = '0;

    // link side
    next_s.active = link_active;
    ev[EV_LINK_UP] = link_active && !s.active;
    ev[EV_LINK_DOWN] = !link_active && s.active;
    ev[EV_COMM_ERR] = |cerr_set;
    if (startup_valid && startup_addr >= STARTUP_MIN && startup_addr <= STARTUP_MAX) begin
      next_s.startup = startup_addr;
      ev[EV_STARTUP] = startup_addr != s.startup;
    end
    next_s.live = s.active ? live_cnt : '0;
    next_s.link_err = !s.active || any_cerr;

    // write channels, address and data taken in either order
    case (s.wr)
      DLS_WR_IDLE: begin
        if (s_axi_awvalid && s.awready) begin
          next_s.aw_got = 1'b1;
          next_s.widx = s_axi_awaddr[ADDR_W-1:2];
        end
        if (s_axi_wvalid && s.wready) begin
          next_s.w_got = 1'b1;
          next_s.wdata = s_axi_wdata;
          next_s.wstrb = s_axi_wstrb;
        end
        if (next_s.aw_got && next_s.w_got) begin
          next_s.wr = DLS_WR_RESP;
          next_s.bvalid = 1'b1;
          next_s.bresp = RESP_SLVERR;
          if (next_s.widx == IDX_IRQ_MASK) begin
            mask_wr = next_s.wstrb[0];
            next_s.bresp = RESP_OKAY;
          end else if (next_s.widx >= IDX_FIRST_WORD && next_s.widx <= IDX_SUMMARY) begin
            // read-only words: write completes, nothing stored
            next_s.bresp = RESP_OKAY;
          end
        end
      end
      DLS_WR_RESP: begin
        if (s_axi_bready) begin
          next_s.wr = DLS_WR_IDLE;
          next_s.bvalid = 1'b0;
          next_s.aw_got = 1'b0;
          next_s.w_got = 1'b0;
        end
      end
      default: begin
        next_s.wr = DLS_WR_IDLE;
      end
    endcase
    next_s.awready = (next_s.wr == DLS_WR_IDLE) && !next_s.aw_got;
    next_s.wready = (next_s.wr == DLS_WR_IDLE) && !next_s.w_got;

    // read channels
    case (s.rd)
      DLS_RD_IDLE: begin
        if (s_axi_arvalid && s.arready) begin
          next_s.rd = DLS_RD_RESP;
          next_s.rvalid = 1'b1;
          next_s.rdata = rd_word;
          next_s.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
          status_rd = (aridx == IDX_IRQ_STATUS);
        end
      end
      DLS_RD_RESP: begin
        if (s_axi_rready) begin
          next_s.rd = DLS_RD_IDLE;
          next_s.rvalid = 1'b0;
        end
      end
      default: begin
        next_s.rd = DLS_RD_IDLE;
      end
    endcase
    next_s.arready = (next_s.rd == DLS_RD_IDLE);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= TOP_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_rd_take(logic [5:0] idx);
    s_axi_arvalid && s_axi_arready && aridx == idx;
  endsequence

  sequence s_good_startup;
    startup_valid && startup_addr >= STARTUP_MIN && startup_addr <= STARTUP_MAX;
  endsequence

  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  a_local_flag: assert property (
    s_rd_take(IDX_LOCAL_WORD) |=> s_axi_rvalid && s_axi_rdata[LOCAL_ACTIVE_BIT] == $past(link_active, 2))
    else $error("local active bit does not follow the link");
  a_startup_store: assert property (
    s_good_startup |=> s_rd_take(IDX_LOCAL_WORD) |=> s_axi_rdata[13:8] == $past(startup_addr, 2))
    else $error("startup address not stored");
  a_startup_reject: assert property (
    startup_valid && startup_addr == STARTUP_RESET |=> $stable(s.startup))
    else $error("out of range startup address stored");
  a_word_pack: assert property (
    s_rd_take(IDX_FIRST_WORD) |=> s_axi_rdata[15:0] ==
      $past({flag_q[3], flag_q[2], flag_q[1], flag_q[0]}) && s_axi_rdata[31:16] == 16'h0000)
    else $error("first status word packed wrong");
  a_frozen: assert property (
    !s.active |=> $stable(flag_q[0]) && $stable(flag_q[NODE_COUNT-1]))
    else $error("node flags moved while inactive");
  a_read_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  a_write_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid ##0 !s_axi_awready)
    else $error("write answer dropped early");
  a_local_pad: assert property (
    s_rd_take(IDX_LOCAL_WORD) |=> !s_axi_rdata[14] && s_axi_rdata[31:16] == 16'h0000)
    else $error("local word spare bits not zero");
  a_sum_err: assert property (
    s_rd_take(IDX_SUMMARY) |=> s_axi_rdata[SUM_ERR_BIT] == $past(!s.active || any_cerr, 2))
    else $error("summary link error bit wrong");
  a_live_idle: assert property (
    !s.active |=> s.live == '0 && s.link_err)
    else $error("summary not idle while inactive");
  a_rd_unmapped: assert property (
    s_axi_arvalid && s_axi_arready && (aridx < IDX_FIRST_WORD || aridx > IDX_SUMMARY)
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_status_clear: assert property (
    s_rd_take(IDX_IRQ_STATUS) |=> irq_status == $past(ev))
    else $error("status not cleared by read");
  a_irq_level: assert property (
    irq == |(irq_status & irq_mask))
    else $error("interrupt line disagrees with status");
  a_rd_refused: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_wr_refused: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_wr_answer: assert property (
    s_wr_both |=> s_axi_bvalid)
    else $error("write answer missing");
  a_mask_store: assert property (
    s_axi_bvalid && s.widx == IDX_IRQ_MASK && s.wstrb[0] |-> irq_mask == s.wdata[EV_W-1:0])
    else $error("mask write not stored");
endmodule : dls_link_status
`default_nettype wire

// ---- verif/dls_node_model.sv ----
// model: remote link nodes, those selected by send sending one frame each per communications cycle
`default_nettype none
module dls_node_model
  import dls_pkg::*;
(
  input wire logic aclk,
  input wire logic go,
  input wire logic slow,
  input wire logic [NODE_COUNT-1:0] send,
  input wire logic [NODE_COUNT-1:0] run,
  input wire logic [NODE_COUNT-1:0] fatal,
  output logic frame_valid,
  output logic [SLOT_W-1:0] frame_slot,
  output logic frame_run,
  output logic frame_fatal,
  output logic cycle_end,
  output logic done
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // frame sequencer
  // ****************************************
  initial begin
    frame_valid = 1'b0;
    frame_slot = 6'h00;
    frame_run = 1'b0;
    frame_fatal = 1'b0;
    cycle_end = 1'b0;
    done = 1'b0;
    forever begin
      @(posedge aclk);
      if (go) begin
        done <= 1'b0;
        for (int i = 0; i < NODE_COUNT; i++) begin
          if (send[i]) begin
            frame_valid <= 1'b1;
            frame_slot <= i[SLOT_W-1:0];
            frame_run <= run[i];
            frame_fatal <= fatal[i];
            @(posedge aclk);
            // released lines show the inverse, never the last frame
            frame_valid <= 1'b0;
            frame_slot <= ~i[SLOT_W-1:0];
            frame_run <= ~run[i];
            frame_fatal <= ~fatal[i];
            @(posedge aclk);
            if (slow) begin
              repeat (3) @(posedge aclk);
            end
          end
        end
        cycle_end <= 1'b1;
        @(posedge aclk);
        cycle_end <= 1'b0;
        done <= 1'b1;
      end else begin
        frame_slot <= frame_slot + 6'h01;
        frame_run <= ~frame_run;
        frame_fatal <= ~frame_fatal;
      end
    end
  end
endmodule : dls_node_model
`default_nettype wire

// ---- verif/dls_link_status_bench.sv ----
// testbench: link status flags, register slave and interrupt
`default_nettype none
module dls_link_status_bench
  import dls_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, link_active, frame_valid, frame_run, frame_fatal, cycle_end;
  logic startup_valid, irq, go, slow, done;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [SLOT_W-1:0] frame_slot, startup_addr;
  logic [NODE_COUNT-1:0] snd, run, fatal;
  logic [31:0] data;
  int num_errors, tests_run;

  dls_link_status dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_active,
    .frame_valid, .frame_slot, .frame_run, .frame_fatal, .cycle_end, .startup_valid,
    .startup_addr, .irq);
  dls_node_model nodes_u (.aclk, .go, .slow, .send(snd), .run, .fatal, .frame_valid,
    .frame_slot, .frame_run, .frame_fatal, .cycle_end, .done);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] ba(input logic [5:0] idx);
    return {idx, 2'b00};
  endfunction : ba
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  task automatic hung(input string what);
    num_errors++;
    $display("unexpected %s: no answer within bound", what);
    wrap_up();
  endtask : hung
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        return;
      end
    end
    hung("write response");
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        return;
      end
    end
    hung("read data");
  endtask : axi_rd
  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp, input string what);
    axi_rd(ba(idx), data, resp);
    check("read resp", {30'h0, resp}, {30'h0, RESP_OKAY});
    check(what, data, exp);
  endtask : rd_chk
  task automatic set_startup(input logic [5:0] a);
    @(posedge aclk);
    startup_addr <= a;
    startup_valid <= 1'b1;
    @(posedge aclk);
    startup_valid <= 1'b0;
  endtask : set_startup
  task automatic link_cycle(input logic [61:0] s, input logic [61:0] r, input logic [61:0] f,
                            input logic sl);
    @(posedge aclk);
    snd <= s;
    run <= r;
    fatal <= f;
    slow <= sl;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    for (int n = 0; n < 2000; n++) begin
      @(posedge aclk);
      if (done === 1'b1) return;
    end
    hung("link cycle");
  endtask : link_cycle

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rd_chk(IDX_FIRST_WORD, 32'h0, "first node word");
    rd_chk(IDX_LOCAL_WORD, 32'h0, "local word");
    rd_chk(IDX_IRQ_STATUS, 32'h0, "irq status");
    axi_wr(ba(IDX_LOCAL_WORD), 32'hffff_ffff, resp);
    check("ro write resp", {30'h0, resp}, {30'h0, RESP_OKAY});
    rd_chk(IDX_LOCAL_WORD, 32'h0, "local word after write");
    axi_wr(ba(6'h3f), 32'h1, resp);
    check("unmapped write resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
    axi_rd(ba(6'h3f), data, resp);
    check("unmapped read resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
    check("unmapped read data", data, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_startup;
    @(posedge aclk);
    link_active <= 1'b1;
    set_startup(STARTUP_MAX);
    rd_chk(IDX_LOCAL_WORD, 32'h0000_be00, "startup max");
    set_startup(6'h3f);
    set_startup(6'h00);
    rd_chk(IDX_LOCAL_WORD, 32'h0000_be00, "startup out of range");
    set_startup(STARTUP_MIN);
    rd_chk(IDX_LOCAL_WORD, 32'h0000_8100, "startup min");
    $display("test startup done");
  endtask : t_startup
  task automatic t_cycles;
    link_cycle(62'h2000_0000_0000_0007, 62'h2000_0000_0000_0003, 62'h2, 1'b0);
    rd_chk(IDX_FIRST_WORD, 32'h0000_48b9, "first cycle word");
    link_cycle(62'h2000_0000_0000_0006, 62'h2000_0000_0000_0004, 62'h2, 1'b1);
    rd_chk(IDX_FIRST_WORD, 32'h0000_49bd, "second cycle word");
    rd_chk(IDX_LOCAL_WORD, 32'h0000_8194, "last slots word");
    rd_chk(IDX_SUMMARY, 32'h0000_0103, "summary active");
    $display("test cycles done");
  endtask : t_cycles
  task automatic t_freeze;
    @(posedge aclk);
    link_active <= 1'b0;
    link_cycle(62'h1, 62'h0, 62'h1, 1'b0);
    rd_chk(IDX_FIRST_WORD, 32'h0000_49bd, "frozen word");
    rd_chk(IDX_LOCAL_WORD, 32'h0000_0194, "inactive local word");
    rd_chk(IDX_SUMMARY, 32'h0000_0100, "summary inactive");
    $display("test freeze done");
  endtask : t_freeze
  task automatic t_irq;
    check("irq masked", {31'h0, irq}, 32'h0);
    axi_wr(ba(IDX_IRQ_MASK), 32'h2, resp);
    repeat (2) @(posedge aclk);
    check("irq unmasked", {31'h0, irq}, 32'h1);
    rd_chk(IDX_IRQ_MASK, 32'h2, "mask readback");
    s_axi_wstrb <= 4'h0;
    axi_wr(ba(IDX_IRQ_MASK), 32'hf, resp);
    s_axi_wstrb <= 4'hf;
    rd_chk(IDX_IRQ_MASK, 32'h2, "mask kept without strobe");
    rd_chk(IDX_IRQ_STATUS, 32'hf, "all events");
    repeat (2) @(posedge aclk);
    check("irq after clear", {31'h0, irq}, 32'h0);
    rd_chk(IDX_IRQ_STATUS, 32'h0, "status cleared");
    $display("test irq done");
  endtask : t_irq

  // ****************************************
  // clock and main sequence
  // ****************************************
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  initial begin
    {aresetn, link_active, startup_valid, go, slow} = 5'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = 22'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    startup_addr = 6'h00;
    {snd, run, fatal} = '0;
    num_errors = 0;
    tests_run = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_startup();
    t_cycles();
    t_freeze();
    t_irq();
    wrap_up();
  end
endmodule : dls_link_status_bench
`default_nettype wire
